// [design/iopt_port.sv]
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "iopt_defines.svh"

module iopt_port (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        ce,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  input  wire logic [31:0]                 pin_in,
  input  wire logic [31:0]                 pin_dir,
  output wire logic                        hreadyout,
  output wire logic                        hresp,
  output wire logic [31:0]                 hrdata,
  output wire logic [31:0]                 out_val,
  output wire iopt_pkg::iopt_cfg_t [31:0]  pin_settings,
  output wire logic [31:0][3:0]            pin_func,
  output wire logic [31:0]                 pull_up,
  output wire logic [31:0]                 pull_dn
);

  iopt_pkg::iopt_req_t            req_ff;
  logic                           req_vld_ff;
  logic                           hrdy_ff;
  logic [31:0]                    hrdata_ff;
  logic [31:0]                    out_val_ff;
  logic [31:0]                    nxt_out_val;
  logic [31:0]                    in_val_ff;
  logic [31:0]                    nxt_in_val;
  logic [31:0]                    sync1_ff;
  logic [31:0]                    sync2_ff;
  logic [31:0]                    samp_ff;
  logic [31:0]                    en32;
  iopt_pkg::iopt_cfg_t [31:0]     cfg_ff;
  logic [31:0][3:0]               func_ff;
  logic [31:0]                    pull_up_ff;
  logic [31:0]                    pull_dn_ff;
  logic [31:0]                    wmask;
  logic [31:0]                    wdata;
  iopt_pkg::iopt_mpc_t            mpc;
  iopt_pkg::iopt_cfg_t            new_cfg;
  logic [31:0]                    mpc_sel;
  logic                           mpc_ok;
  logic                           take;

  // Byte lanes touched by a transfer
  function automatic logic [31:0] lane_mask(input logic [2:0] sz, input logic [1:0] a);
    logic [31:0] m;
    m = 32'h0000_0000;
    case (sz)
      `IOPT_SIZE_BYTE: m = 32'h0000_00ff << {a, 3'h0};
      `IOPT_SIZE_HALF: m = a[1] ? 32'hffff_0000 : 32'h0000_ffff;
      default:         m = 32'hffff_ffff;
    endcase
    return m;
  endfunction

  // Data-phase write hit on one word; byte and half lanes land in it
  function automatic logic wr_hit(input iopt_pkg::iopt_req_t r, input logic v,
                                  input logic [7:0] ofs);
    return v && r.wr && (r.addr[7:2] == ofs[7:2]);
  endfunction

  // Spread a per-pin select to four bits each
  function automatic logic [127:0] spread4(input logic [31:0] s);
    logic [127:0] r;
    r = 128'h0;
    for (int i = 0; i < `IOPT_PINS; i++)
    begin
      r[i*4 +: 4] = {4{s[i]}};
    end
    return r;
  endfunction

  assign take      = hsel && htrans[1] && hready;
  assign wmask     = lane_mask(req_ff.size, req_ff.addr[1:0]);
  assign wdata     = hwdata & wmask;
  assign mpc       = iopt_pkg::iopt_mpc_t'(hwdata);
  assign mpc_ok    = wr_hit(req_ff, req_vld_ff, `IOPT_OFS_MPC)
                     && (req_ff.size == `IOPT_SIZE_WORD);
  assign mpc_sel   = mpc.half_word_select ? {mpc.pin_select_mask, 16'h0000}
                                          : {16'h0000, mpc.pin_select_mask};
  assign new_cfg   = '{mpc.drive_strength, mpc.pull_resistor_enable,
                       mpc.input_buffer_enable, mpc.function_mux_enable};

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_ff     <= '0;
      req_vld_ff <= 1'b0;
    end
    else if (ce)
    begin
      req_vld_ff <= take;
      req_ff.wr   <= hwrite;
      req_ff.addr <= haddr[7:0];
      req_ff.size <= hsize;
    end
  end

  // Shared output value behind all four views
  always_comb
  begin
    nxt_out_val = out_val_ff;
    if (wr_hit(req_ff, req_vld_ff, `IOPT_OFS_OUT))
      nxt_out_val = (out_val_ff & ~wmask) | wdata;
    if (wr_hit(req_ff, req_vld_ff, `IOPT_OFS_SET))
      nxt_out_val = out_val_ff | wdata;
    if (wr_hit(req_ff, req_vld_ff, `IOPT_OFS_CLR))
      nxt_out_val = out_val_ff & ~wdata;
    if (wr_hit(req_ff, req_vld_ff, `IOPT_OFS_TGL))
      nxt_out_val = out_val_ff ^ wdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      out_val_ff <= `IOPT_RST_WORD;
    else if (ce)
      out_val_ff <= nxt_out_val;
  end

  // Pull direction follows output value on pulled inputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pull_up_ff <= `IOPT_RST_WORD;
      pull_dn_ff <= `IOPT_RST_WORD;
    end
    else if (ce)
    begin
      for (int i = 0; i < `IOPT_PINS; i++)
      begin
        pull_up_ff[i] <= !pin_dir[i] && cfg_ff[i].pull_resistor_enable && out_val_ff[i];
        pull_dn_ff[i] <= !pin_dir[i] && cfg_ff[i].pull_resistor_enable && !out_val_ff[i];
      end
    end
  end

  // Sampling request register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      samp_ff <= `IOPT_RST_WORD;
    else if (ce && wr_hit(req_ff, req_vld_ff, `IOPT_OFS_SAMP))
      samp_ff <= (samp_ff & ~wmask) | wdata;
  end

  // Group enables: any request wakes all eight
  always_comb
  begin
    en32 = 32'h0000_0000;
    for (int g = 0; g < `IOPT_GROUPS; g++)
    begin
      en32[g*`IOPT_GRP_W +: `IOPT_GRP_W] = {`IOPT_GRP_W{|samp_ff[g*`IOPT_GRP_W +: `IOPT_GRP_W]}};
    end
  end

  // Pin synchronizer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_ff <= `IOPT_RST_WORD;
      sync2_ff <= `IOPT_RST_WORD;
    end
    else if (ce)
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Input value tracks sampled level in enabled groups
  assign nxt_in_val = (sync2_ff & en32) | (in_val_ff & ~en32);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      in_val_ff <= `IOPT_RST_WORD;
    else if (ce)
      in_val_ff <= nxt_in_val;
  end

  // Atomic multi-pin update in one edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_ff  <= '0;
      func_ff <= '0;
    end
    else if (ce && mpc_ok)
    begin
      for (int i = 0; i < `IOPT_PINS; i++)
      begin
        if (mpc_sel[i] && mpc.write_pin_settings)
          cfg_ff[i] <= new_cfg;
        if (mpc_sel[i] && mpc.write_function_select)
          func_ff[i] <= mpc.peripheral_function_code;
      end
    end
  end

  // Read data captured at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= `IOPT_RST_WORD;
    else if (ce && take && !hwrite)
    begin
      case (haddr[7:0])
        `IOPT_OFS_OUT, `IOPT_OFS_SET,
        `IOPT_OFS_CLR, `IOPT_OFS_TGL: hrdata_ff <= nxt_out_val;
        `IOPT_OFS_IN:                 hrdata_ff <= nxt_in_val;
        `IOPT_OFS_MPC:                hrdata_ff <= `IOPT_RST_WORD;
        default:                      hrdata_ff <= `IOPT_RST_WORD;
      endcase
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdy_ff <= 1'b1;
    else if (ce)
      hrdy_ff <= 1'b1;
  end

  assign hreadyout    = hrdy_ff;
  assign hresp        = 1'b0 & hrdy_ff;
  assign hrdata       = hrdata_ff;
  assign out_val      = out_val_ff;
  assign pin_settings = cfg_ff;
  assign pin_func     = func_ff;
  assign pull_up      = pull_up_ff;
  assign pull_dn      = pull_dn_ff;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic         tgl_wr;
  logic         mpc_part;
  logic [127:0] sel_cfg;
  logic [127:0] cfg_flat;
  logic [127:0] new_rep;
  logic [127:0] func_rep;
  logic [127:0] func_flat;

  assign tgl_wr    = wr_hit(req_ff, req_vld_ff, `IOPT_OFS_TGL) && ce;
  assign mpc_part  = wr_hit(req_ff, req_vld_ff, `IOPT_OFS_MPC) && !mpc_ok && ce;
  assign sel_cfg   = spread4(mpc_sel);
  assign cfg_flat  = cfg_ff;
  assign func_flat = func_ff;
  assign new_rep   = {32{new_cfg}};
  assign func_rep  = {32{mpc.peripheral_function_code}};

  toggle_flip_a: assert property (tgl_wr |=>
    out_val_ff == ($past(out_val_ff) ^ $past(wdata)))
    else $error("toggle did not invert output bits");
  zero_keep_a: assert property (tgl_wr |=>
    ((out_val_ff ^ $past(out_val_ff)) & ~$past(wdata)) == 32'h0)
    else $error("toggle zero bit changed output");
  pull_swap_a: assert property (ce |=>
    ((pull_up_ff & ~$past(out_val_ff)) | (pull_dn_ff & $past(out_val_ff))) == 32'h0)
    else $error("pull direction not from output value");
  view_share_a: assert property ((ce && take && !hwrite && haddr[7:0] == `IOPT_OFS_TGL) |=>
    hrdata_ff == out_val_ff)
    else $error("toggle view differs from output value");
  in_follow_a: assert property (ce |=>
    (in_val_ff & $past(en32)) == ($past(sync2_ff) & $past(en32)))
    else $error("input value not following sampler");
  grp_hold_a: assert property (ce |=>
    (in_val_ff & ~$past(en32)) == ($past(in_val_ff) & ~$past(en32)))
    else $error("disabled group input value changed");
  grp_span_a: assert property ((|samp_ff[7:0]) |->
    en32[7:0] == 8'hff)
    else $error("group sampler not fully enabled");
  partial_drop_a: assert property (mpc_part |=>
    cfg_flat == $past(cfg_flat) && func_flat == $past(func_flat))
    else $error("narrow multi-pin write took effect");
  mpc_zero_a: assert property ((ce && take && !hwrite && haddr[7:0] == `IOPT_OFS_MPC) |=>
    hrdata_ff == 32'h0)
    else $error("multi-pin register read nonzero");
  cfg_load_a: assert property ((ce && mpc_ok && mpc.write_pin_settings) |=>
    (cfg_flat & $past(sel_cfg)) == ($past(new_rep) & $past(sel_cfg)))
    else $error("selected pin settings not loaded");
  func_load_a: assert property ((ce && mpc_ok && mpc.write_function_select) |=>
    (func_flat & $past(sel_cfg)) == ($past(func_rep) & $past(sel_cfg)))
    else $error("selected function code not loaded");
  unsel_keep_a: assert property ((ce && mpc_ok) |=>
    (cfg_flat & ~$past(sel_cfg)) == ($past(cfg_flat) & ~$past(sel_cfg)))
    else $error("unselected pin settings changed");

  toggle_seen_c: cover property (tgl_wr && wdata != 32'h0);
  mpc_both_c:    cover property (ce && mpc_ok && mpc.write_pin_settings
                                 && mpc.write_function_select && mpc.half_word_select);
  mpc_part_c:    cover property (mpc_part);

endmodule

// [include/iopt_defines.svh]
`ifndef IOPT_DEFINES_SVH
`define IOPT_DEFINES_SVH

// Register byte offsets
`define IOPT_OFS_OUT      8'h10
`define IOPT_OFS_CLR      8'h14
`define IOPT_OFS_SET      8'h18
`define IOPT_OFS_TGL      8'h1c
`define IOPT_OFS_IN       8'h20
`define IOPT_OFS_SAMP     8'h24
`define IOPT_OFS_MPC      8'h28

// Reset values
`define IOPT_RST_WORD     32'h0000_0000
`define IOPT_RST_CFG      4'h0
`define IOPT_RST_FUNC     4'h0

// Bus encodings
`define IOPT_SIZE_BYTE    3'h0
`define IOPT_SIZE_HALF    3'h1
`define IOPT_SIZE_WORD    3'h2

// Port geometry
`define IOPT_PINS         32
`define IOPT_GRP_W        8
`define IOPT_GROUPS       4
`define IOPT_HALF         16

`endif

// [include/iopt_pkg.sv]
package iopt_pkg;

  // Per-pin settings
  typedef struct packed {
    logic drive_strength;
    logic pull_resistor_enable;
    logic input_buffer_enable;
    logic function_mux_enable;
  } iopt_cfg_t;

  // Multi-pin configuration word layout
  typedef struct packed {
    logic        half_word_select;
    logic        write_pin_settings;
    logic        rsv29;
    logic        write_function_select;
    logic [3:0]  peripheral_function_code;
    logic        rsv23;
    logic        drive_strength;
    logic [2:0]  rsv21;
    logic        pull_resistor_enable;
    logic        input_buffer_enable;
    logic        function_mux_enable;
    logic [15:0] pin_select_mask;
  } iopt_mpc_t;

  // Latched bus address phase
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [2:0] size;
  } iopt_req_t;

endpackage

// [verif/tb_top.sv]
`timescale 1ns/100ps

module tb_top;
  logic                            hclk = 1'b0;
  logic                            hresetn = 1'b0;
  logic                            ce = 1'b1;
  logic                            hsel = 1'b1;
  logic                            hwrite = 1'b0;
  logic [1:0]                      htrans = 2'h0;
  logic [2:0]                      hsize = 3'h2;
  logic [31:0]                     haddr = 32'h0;
  logic [31:0]                     hwdata = 32'h0;
  logic [31:0]                     pin_in = 32'h0;
  logic [31:0]                     pin_dir = 32'h0;
  logic [31:0]                     exp_out = 32'h0;
  logic [3:0]                      exp_cfg [32] = '{default: 4'h0};
  logic [3:0]                      exp_func [32] = '{default: 4'h0};
  wire                             hreadyout;
  wire                             hresp;
  wire [31:0]                      hrdata;
  wire [31:0]                      out_val;
  wire [31:0]                      pull_up;
  wire [31:0]                      pull_dn;
  wire iopt_pkg::iopt_cfg_t [31:0] pin_settings;
  wire [31:0][3:0]                 pin_func;
  int                              n_mismatch = 0;
  int                              samples_checked = 0;
  int                              cyc = 0;

  iopt_port dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .pin_in(pin_in), .pin_dir(pin_dir), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .out_val(out_val), .pin_settings(pin_settings), .pin_func(pin_func),
    .pull_up(pull_up), .pull_dn(pull_dn));

  // Clock and hang guard
  always #5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end

  task results;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  // Single transfer; called right after a rising edge
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] s,
            output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    hsize <= s;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] s = 3'h2);
    logic [31:0] r;
    xfer(1'b1, a, d, s, r);
  endtask

  task rdchk(input logic [31:0] a, input logic [31:0] e, input string name);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, 3'h2, r);
    chk(name, e, r);
    chk("bus_response", 32'h0000_0002, {30'h0, hreadyout, hresp});
  endtask

  // Multi-pin word write plus its expected effect on the pin model
  task mpc(input logic [31:0] w);
    int p;
    wr(32'h28, w);
    for (int i = 0; i < 16; i++)
    begin
      p = i + (w[31] ? 16 : 0);
      if (w[i] && w[30])
        exp_cfg[p] = {w[22], w[18:16]};
      if (w[i] && w[28])
        exp_func[p] = w[27:24];
    end
  endtask

  task check_pins;
    logic [31:0] pm;
    repeat (2) @(posedge hclk);
    #1;
    for (int i = 0; i < 32; i++)
    begin
      pm[i] = exp_cfg[i][2];
      chk("pin_settings", {28'h0, exp_cfg[i]}, {28'h0, pin_settings[i]});
      chk("pin_func", {28'h0, exp_func[i]}, {28'h0, pin_func[i]});
    end
    chk("out_val", exp_out, out_val);
    chk("pull_up", ~pin_dir & pm & exp_out, pull_up);
    chk("pull_dn", ~pin_dir & pm & ~exp_out, pull_dn);
    @(posedge hclk);
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(32'h1c, 32'h0, "toggle_reset");
    rdchk(32'h20, 32'h0, "input_reset");
    check_pins();
    // Toggle word, toggle one byte lane, zero toggle
    wr(32'h1c, 32'ha5a5_0f0f);
    wr(32'h1d, 32'h0000_ff00, 3'h0);
    wr(32'h1c, 32'h0);
    exp_out = 32'ha5a5_f00f;
    check_pins();
    wr(32'h14, 32'h0000_000f);
    wr(32'h18, 32'h3000_0000);
    wr(32'h12, 32'h4a4a_0000, 3'h1);
    exp_out = 32'h4a4a_f000;
    for (int a = 32'h10; a <= 32'h1c; a += 4)
      rdchk(a, exp_out, "output_views");
    // Not taken when disabled or not selected
    ce <= 1'b0;
    wr(32'h1c, 32'hffff_ffff);
    ce <= 1'b1;
    hsel <= 1'b0;
    wr(32'h1c, 32'hffff_ffff);
    hsel <= 1'b1;
    rdchk(32'h1c, exp_out, "ignored_toggle");
    // Multi-pin configuration
    wr(32'h28, 32'hd746_ffff, 3'h1);
    wr(32'h28, 32'hd746_ffff, 3'h0);
    check_pins();
    mpc(32'hd746_000f);
    mpc(32'h1900_8001);
    mpc(32'h4001_0002);
    mpc(32'h2000_ffff);
    check_pins();
    rdchk(32'h28, 32'h0, "multi_pin_read");
    // Pull direction follows the toggled output value
    pin_dir <= 32'h0000_ffff;
    check_pins();
    wr(32'h1c, 32'h000f_0000);
    exp_out ^= 32'h000f_0000;
    check_pins();
    // Input sampling per eight-pin group
    pin_in <= 32'h1234_5678;
    repeat (4) @(posedge hclk);
    rdchk(32'h20, 32'h0, "input_disabled");
    wr(32'h24, 32'h0000_0100);
    repeat (4) @(posedge hclk);
    rdchk(32'h20, 32'h0000_5600, "input_group");
    rdchk(32'h24, 32'h0, "sampling_read");
    wr(32'h24, 32'h0101_0101);
    pin_in <= 32'hedcb_a987;
    repeat (4) @(posedge hclk);
    rdchk(32'h20, 32'hedcb_a987, "input_all");
    wr(32'h20, 32'h0);
    pin_in <= 32'h0;
    repeat (4) @(posedge hclk);
    rdchk(32'h20, 32'h0, "input_low");
    // Unmapped place
    wr(32'h04, 32'hffff_ffff);
    rdchk(32'h04, 32'h0, "unmapped");
    rdchk(32'h1c, exp_out, "output_after");
    results();
  end
endmodule
